// ==== shared/gpw_pkg.sv ====
// Purpose: constants for the two-port gpio block with pull-high and wake
// Assumes: one 40 MHz clock; registers reached by a register select index
// Notes:
package gpw_pkg;
    // clock rate
    localparam int unsigned CLK_HZ = 40_000_000;
    // port widths
    localparam int unsigned PA_W = 8;
    localparam int unsigned PB_W = 6;
    // register select width and indices
    localparam int unsigned SEL_W = 3;
    localparam logic [2:0] IDX_PA_DATA = 3'h0;
    localparam logic [2:0] IDX_PA_DIR = 3'h1;
    localparam logic [2:0] IDX_PA_PU = 3'h2;
    localparam logic [2:0] IDX_PA_WAKE = 3'h3;
    localparam logic [2:0] IDX_PB_DATA = 3'h4;
    localparam logic [2:0] IDX_PB_DIR = 3'h5;
    localparam logic [2:0] IDX_PB_PU = 3'h6;
    localparam logic [2:0] IDX_REMAP = 3'h7;
    // values after reset
    localparam logic [7:0] RST_PA_DATA = 8'hff;
    localparam logic [7:0] RST_PA_DIR = 8'hff;
    localparam logic [7:0] RST_PA_PU = 8'h00;
    localparam logic [7:0] RST_PA_WAKE = 8'h00;
    localparam logic [5:0] RST_PB_DATA = 6'h3f;
    localparam logic [5:0] RST_PB_DIR = 6'h3f;
    localparam logic [5:0] RST_PB_PU = 6'h00;
    localparam logic [7:0] RST_REMAP = 8'h50;
    // synchroniser depth for pins
    localparam int unsigned SYNC_STAGES = 2;
endpackage

// ==== core/gpw_ports.sv ====
// Purpose: port a (8 pins) and port b (6 pins) with direction, latch,
//          pull-high select and port a falling-edge wake
// Assumes: cpu reaches registers by select index, write and read strobes
//          strobes and soft resets come from logic on clk, pins do not
// Notes: clock must run while halted for the wake detector to see edges
//        input bits read back the pin as it stood two clocks earlier
//        a watchdog reset while halted leaves every register alone
//        remap control is plain storage, its lock field is not enforced
//        wake_req is a one-clock pulse per falling edge on a selected pin while halted
`timescale 1ns/1ps
module gpw_ports #(
    parameter int unsigned PA_BITS = gpw_pkg::PA_W,
    parameter int unsigned PB_BITS = gpw_pkg::PB_W
) (
    input wire logic clk,
    input wire logic arst_n,
    // soft reset requests and halt state, all on clk
    input wire logic ext_lvr_rst,
    input wire logic wdt_rst,
    input wire logic halted,
    // register access strobes
    input wire logic [gpw_pkg::SEL_W-1:0] reg_sel,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    // port a pins
    input wire logic [7:0] pa_i,
    output logic [7:0] pa_o,
    output logic [7:0] pa_oe,
    output logic [7:0] pa_pu_en,
    // port b pins
    input wire logic [5:0] pb_i,
    output logic [5:0] pb_o,
    output logic [5:0] pb_oe,
    output logic [5:0] pb_pu_en,
    // stored configuration and wake
    output logic [7:0] remap_ctrl,
    output logic wake_req
);

    // refuse widths the fixed register layout cannot serve
    // every register is one byte with a fixed bit layout
    if (PA_BITS != 8 || PB_BITS != 6) begin : g_width_check
        $error("gpw_ports: port widths fixed at 8 and 6");
    end

    // configuration registers
    // power-on and soft resets load the same package defaults
    logic [7:0] pa_data_q, pa_data_d; // port a output latch
    logic [7:0] pa_dir_q, pa_dir_d; // port a direction, 1 = input
    logic [7:0] pa_pu_q, pa_pu_d; // port a pull-high select
    logic [7:0] pa_wake_q, pa_wake_d; // port a wake select
    logic [5:0] pb_data_q, pb_data_d; // port b output latch
    logic [5:0] pb_dir_q, pb_dir_d; // port b direction
    logic [5:0] pb_pu_q, pb_pu_d; // port b pull-high select
    logic [7:0] remap_q, remap_d; // remap control, stored only

    // pin synchronisers and wake state
    // stage one of a synchroniser is read by stage two only
    logic [7:0] pa_s1_q, pa_s2_q; // port a sync stages
    logic [5:0] pb_s1_q, pb_s2_q; // port b sync stages
    logic [7:0] pa_prev_q, pa_prev_d; // last synced port a level
    logic wake_q, wake_d; // wake request pulse
    logic [7:0] rd_q, rd_d; // read data register

    // soft reset: watchdog while halted keeps everything
    // external and low-voltage resets always reload the defaults
    // a soft reset outranks a write landing on the same edge
    logic soft_rst;
    assign soft_rst = ext_lvr_rst | (wdt_rst & ~halted);

    // live pin view merged with latch per direction
    // input bits show the synced pin, output bits show the latch
    logic [7:0] pa_view;
    logic [5:0] pb_view;
    for (genvar k = 0; k < 8; k++) begin : g_pa_view
        // one mux per port a pin
        assign pa_view[k] = pa_dir_q[k] ? pa_s2_q[k] : pa_data_q[k];
    end
    for (genvar k = 0; k < 6; k++) begin : g_pb_view
        // one mux per port b pin
        assign pb_view[k] = pb_dir_q[k] ? pb_s2_q[k] : pb_data_q[k];
    end

    // next values of the register file
    // every register holds unless a soft reset or a write moves it
    always_comb begin
        pa_data_d = pa_data_q;
        pa_dir_d = pa_dir_q;
        pa_pu_d = pa_pu_q;
        pa_wake_d = pa_wake_q;
        pb_data_d = pb_data_q;
        pb_dir_d = pb_dir_q;
        pb_pu_d = pb_pu_q;
        remap_d = remap_q;
        if (soft_rst) begin
            // defaults after external, low-voltage or normal watchdog reset
            pa_data_d = gpw_pkg::RST_PA_DATA;
            pa_dir_d = gpw_pkg::RST_PA_DIR;
            pa_pu_d = gpw_pkg::RST_PA_PU;
            pa_wake_d = gpw_pkg::RST_PA_WAKE;
            pb_data_d = gpw_pkg::RST_PB_DATA;
            pb_dir_d = gpw_pkg::RST_PB_DIR;
            pb_pu_d = gpw_pkg::RST_PB_PU;
            remap_d = gpw_pkg::RST_REMAP;
        end else if (wr_en) begin
            // latches change only on a write to them
            // port b keeps six bits, the upper two are dropped
            // remap control has no lock here, every write lands
            case (reg_sel)
                gpw_pkg::IDX_PA_DATA: pa_data_d = wr_data;
                gpw_pkg::IDX_PA_DIR: pa_dir_d = wr_data;
                gpw_pkg::IDX_PA_PU: pa_pu_d = wr_data;
                gpw_pkg::IDX_PA_WAKE: pa_wake_d = wr_data;
                gpw_pkg::IDX_PB_DATA: pb_data_d = wr_data[5:0];
                gpw_pkg::IDX_PB_DIR: pb_dir_d = wr_data[5:0];
                gpw_pkg::IDX_PB_PU: pb_pu_d = wr_data[5:0];
                gpw_pkg::IDX_REMAP: remap_d = wr_data;
                default: remap_d = remap_q;
            endcase
        end
    end

    // register file flops
    // power-on reset is asynchronous, the soft resets are not
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pa_data_q <= gpw_pkg::RST_PA_DATA;
            pa_dir_q <= gpw_pkg::RST_PA_DIR;
            pa_pu_q <= gpw_pkg::RST_PA_PU;
            pa_wake_q <= gpw_pkg::RST_PA_WAKE;
            pb_data_q <= gpw_pkg::RST_PB_DATA;
            pb_dir_q <= gpw_pkg::RST_PB_DIR;
            pb_pu_q <= gpw_pkg::RST_PB_PU;
            remap_q <= gpw_pkg::RST_REMAP;
        end else begin
            pa_data_q <= pa_data_d;
            pa_dir_q <= pa_dir_d;
            pa_pu_q <= pa_pu_d;
            pa_wake_q <= pa_wake_d;
            pb_data_q <= pb_data_d;
            pb_dir_q <= pb_dir_d;
            pb_pu_q <= pb_pu_d;
            remap_q <= remap_d;
        end
    end

    // two-flop pin synchronisers, stage one feeds stage two only
    // pins idle high, so reset fills the stages with ones
    // that keeps a false falling edge from following reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pa_s1_q <= 8'hff;
            pa_s2_q <= 8'hff;
            pb_s1_q <= 6'h3f;
            pb_s2_q <= 6'h3f;
        end else begin
            pa_s1_q <= pa_i;
            pa_s2_q <= pa_s1_q;
            pb_s1_q <= pb_i;
            pb_s2_q <= pb_s1_q;
        end
    end

    // read mux and wake detector next values
    // an idle cycle leaves the last read data standing
    always_comb begin
        rd_d = rd_q;
        if (rd_en) begin
            // sample at the read, nothing held from before
            // port b reads pad the two unimplemented bits with zero
            case (reg_sel)
                gpw_pkg::IDX_PA_DATA: rd_d = pa_view;
                gpw_pkg::IDX_PA_DIR: rd_d = pa_dir_q;
                gpw_pkg::IDX_PA_PU: rd_d = pa_pu_q;
                gpw_pkg::IDX_PA_WAKE: rd_d = pa_wake_q;
                gpw_pkg::IDX_PB_DATA: rd_d = {2'h0, pb_view};
                gpw_pkg::IDX_PB_DIR: rd_d = {2'h0, pb_dir_q};
                gpw_pkg::IDX_PB_PU: rd_d = {2'h0, pb_pu_q};
                gpw_pkg::IDX_REMAP: rd_d = remap_q;
                default: rd_d = 8'h00;
            endcase
        end
        // one pulse per falling edge of an enabled pin while halted
        // prev is the synced level one clock older than stage two
        // a pin held low gives no further pulse
        pa_prev_d = pa_s2_q;
        wake_d = halted & |(pa_prev_q & ~pa_s2_q & pa_wake_q);
    end

    // read data and wake flops
    // prev resets high like the pins, so no edge follows reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_q <= 8'h00;
            pa_prev_q <= 8'hff;
            wake_q <= 1'b0;
        end else begin
            rd_q <= rd_d;
            pa_prev_q <= pa_prev_d;
            wake_q <= wake_d;
        end
    end

    // pin drive: direction zero drives the latch push-pull
    // the output enable is high while the pin is driven
    // pull-high only on input pins with select set
    for (genvar k = 0; k < 8; k++) begin : g_pa_pin
        // port a pin k
        assign pa_o[k] = pa_data_q[k];
        assign pa_oe[k] = ~pa_dir_q[k];
        assign pa_pu_en[k] = pa_dir_q[k] & pa_pu_q[k];
    end
    for (genvar k = 0; k < 6; k++) begin : g_pb_pin
        // port b pin k
        assign pb_o[k] = pb_data_q[k];
        assign pb_oe[k] = ~pb_dir_q[k];
        assign pb_pu_en[k] = pb_dir_q[k] & pb_pu_q[k];
    end
    // register values and pulses seen outside come from flops
    assign remap_ctrl = remap_q;
    assign rd_data = rd_q;
    assign wake_req = wake_q;

endmodule // gpw_ports

// ==== sim/gpw_ports_asserts.sv ====
// Purpose: port-level checker for gpw_ports
// Assumes: one clock, async low reset
// Notes: bound to every gpw_ports instance
`timescale 1ns/1ps
module gpw_ports_asserts (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ext_lvr_rst,
    input wire logic wdt_rst,
    input wire logic halted,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic wake_req,
    input wire logic [gpw_pkg::SEL_W-1:0] reg_sel,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic [7:0] pa_i,
    input wire logic [7:0] pa_o,
    input wire logic [7:0] pa_oe,
    input wire logic [7:0] pa_pu_en,
    input wire logic [7:0] remap_ctrl,
    input wire logic [5:0] pb_oe,
    input wire logic [5:0] pb_pu_en
);
    // soft reset that reloads defaults
    logic srst;
    assign srst = ext_lvr_rst | (wdt_rst & ~halted);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_pull_on_input: assert property (!(pa_pu_en & pa_oe) && !(pb_pu_en & pb_oe))
        else $error("pull-high on driven pin");
    a_dir_write: assert property (wr_en && reg_sel == 3'h1 && !srst |=> pa_oe == ~$past(wr_data))
        else $error("direction write wrong");
    a_soft_load: assert property (srst |=> pa_oe == 8'h00 && pb_oe == 6'h00 && remap_ctrl == 8'h50
        && pa_o == 8'hff && pa_pu_en == 8'h00)
        else $error("soft reset defaults wrong");
    a_idle_keep: assert property (wdt_rst && halted && !ext_lvr_rst && !wr_en |=> $stable(remap_ctrl))
        else $error("idle watchdog changed state");
    a_latch_hold: assert property (!wr_en && !srst |=> $stable(pa_o))
        else $error("latch changed unwritten");
    a_wake_once: assert property (wake_req |=> !wake_req)
        else $error("wake pulse too long");
    a_wake_cause: assert property (wake_req |-> $past(halted) && |($past(pa_i, 4) & ~$past(pa_i, 3)))
        else $error("wake without falling edge");
    a_out_read: assert property (rd_en && reg_sel == 3'h0 && pa_oe == 8'hff |=> rd_data == $past(pa_o))
        else $error("output read not latch");
    a_pb_upper: assert property (rd_en && reg_sel[2] && reg_sel != 3'h7 |=> rd_data[7:6] == 2'h0)
        else $error("port b upper bits set");
    c_wake: cover property (wake_req);
    c_idle_wdt: cover property (wdt_rst && halted);
    c_out_read: cover property (rd_en && reg_sel == 3'h0 && pa_oe == 8'hff);
endmodule // gpw_ports_asserts
bind gpw_ports gpw_ports_asserts i_gpw_ports_asserts (
    .clk(clk),
    .arst_n(arst_n),
    .ext_lvr_rst(ext_lvr_rst),
    .wdt_rst(wdt_rst),
    .halted(halted),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .wake_req(wake_req),
    .reg_sel(reg_sel),
    .wr_data(wr_data),
    .rd_data(rd_data),
    .pa_i(pa_i),
    .pa_o(pa_o),
    .pa_oe(pa_oe),
    .pa_pu_en(pa_pu_en),
    .remap_ctrl(remap_ctrl),
    .pb_oe(pb_oe),
    .pb_pu_en(pb_pu_en)
);

// ==== sim/gpw_pins.sv ====
// Purpose: pin model, outside circuit plus pull-high
// Assumes: outside drive never meets an output
// Notes: floating lines toggle each cycle
`timescale 1ns/1ps
module gpw_pins #(parameter int W = 8) (
    input wire logic clk,
    input wire logic [W-1:0] o,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] pu,
    input wire logic [W-1:0] ext,
    input wire logic [W-1:0] ext_en,
    output logic [W-1:0] pin
);
    // wandering level for undriven lines
    logic [W-1:0] wander = '0;
    always @(posedge clk) wander <= ~wander;
    // output first, then outside drive, then pull-high
    assign pin = (oe & o) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pu | wander));
endmodule // gpw_pins

// ==== sim/gpw_ports_tb.sv ====
// Purpose: self-checking bench for gpw_ports
// Assumes: inputs change on falling edge
// Notes: table rows are sel, write, read-back
`timescale 1ns/1ps
module gpw_ports_tb;
    logic clk = 1'b0, arst_n = 1'b0, ext_lvr_rst = 1'b0, wdt_rst = 1'b0, halted = 1'b0;
    logic wr_en = 1'b0, rd_en = 1'b0, wake_req;
    logic [2:0] reg_sel = 3'h0;
    logic [7:0] wr_data = 8'h00, rd_data, pa_i, pa_o, pa_oe, pa_pu_en, remap_ctrl, ext_a = 8'hff;
    logic [5:0] pb_i, pb_o, pb_oe, pb_pu_en;
    int miscompares = 0, n_compared = 0, pulses;
    logic [23:0] rows [8] = '{24'h010000, 24'h00a5a5, 24'h025a5a, 24'h03ffff,
        24'h05ff3f, 24'h06ff3f, 24'h04003f, 24'h07a3a3};
    always #12.5 clk = ~clk;
    gpw_ports i_gpw_ports (
        .clk(clk),
        .arst_n(arst_n),
        .ext_lvr_rst(ext_lvr_rst),
        .wdt_rst(wdt_rst),
        .halted(halted),
        .reg_sel(reg_sel),
        .wr_en(wr_en),
        .wr_data(wr_data),
        .rd_en(rd_en),
        .rd_data(rd_data),
        .pa_i(pa_i),
        .pa_o(pa_o),
        .pa_oe(pa_oe),
        .pa_pu_en(pa_pu_en),
        .pb_i(pb_i),
        .pb_o(pb_o),
        .pb_oe(pb_oe),
        .pb_pu_en(pb_pu_en),
        .remap_ctrl(remap_ctrl),
        .wake_req(wake_req)
    );
    gpw_pins #(.W(8)) i_gpw_pins_a (.clk(clk), .o(pa_o), .oe(pa_oe), .pu(pa_pu_en), .ext(ext_a),
        .ext_en(8'hff), .pin(pa_i));
    gpw_pins #(.W(6)) i_gpw_pins_b (.clk(clk), .o(pb_o), .oe(pb_oe), .pu(pb_pu_en), .ext(6'h00),
        .ext_en(6'h00), .pin(pb_i));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] s, input logic [7:0] d);
        @(negedge clk) {wr_en, reg_sel, wr_data} = {1'b1, s[2:0], d};
        @(negedge clk) wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] s, input logic [7:0] e);
        @(negedge clk) {rd_en, reg_sel} = {1'b1, s[2:0]};
        @(negedge clk) rd_en = 1'b0;
        chk(rd_data, e);
    endtask
    task automatic wake(input logic [7:0] v);
        @(negedge clk) ext_a = v;
        pulses = 0;
        repeat (8) @(negedge clk) pulses += int'(wake_req);
    endtask
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        chk(pa_oe, 8'h00);
        chk(remap_ctrl, 8'h50);
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        chk({2'h0, pb_o}, 8'h00);
        chk({2'h0, pb_pu_en}, 8'h3f);
        wr(8'h01, 8'h0f);
        ext_a = 8'h96;
        repeat (2) @(negedge clk); // pin passes the two-flop synchroniser
        rd(8'h00, 8'ha6);
        chk(pa_pu_en, 8'h0a);
        ext_a = 8'hff;
        wr(8'h01, 8'hff);
        wr(8'h03, 8'h10);
        halted = 1'b1;
        wake(8'hef);
        chk(8'(pulses), 8'h01);
        wake(8'hee);
        chk(8'(pulses), 8'h00);
        wake(8'hff);
        halted = 1'b0;
        wake(8'hef);
        chk(8'(pulses), 8'h00);
        @(negedge clk) {halted, wdt_rst} = 2'b11;
        @(negedge clk) wdt_rst = 1'b0;
        chk(remap_ctrl, 8'ha3);
        @(negedge clk) {halted, wdt_rst} = 2'b01;
        @(negedge clk) wdt_rst = 1'b0;
        chk(remap_ctrl, 8'h50);
        chk(pa_pu_en, 8'h00);
        wr(8'h07, 8'h11);
        @(negedge clk) ext_lvr_rst = 1'b1;
        @(negedge clk) ext_lvr_rst = 1'b0;
        chk(remap_ctrl, 8'h50);
        // mid-run power-on reset brings every output back to defaults
        @(negedge clk) arst_n = 1'b0;
        @(negedge clk) arst_n = 1'b1;
        chk(pa_o, 8'hff);
        chk({2'h0, pb_o}, 8'h3f);
        chk({2'h0, pb_oe}, 8'h00);
        chk(rd_data, 8'h00);
        test_done();
    end
endmodule // gpw_ports_tb
